// ---- src/lpm_dev.sv ----
// Decided for this implementation: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - mode field picks stop, wait, doze, run
// - software sets mode before the halt
// - mode field accessible regardless of privilege
// - stop select gates clock_output_pin, pll, oscillator
// - system clock held low in stop
// - standby bit picks pseudo or full standby
// - standby bit ignored without detector enable
// - software writes reserved bits as zero
// - mode zero halts, clocks keep running
// - entry idles core, gates selected clocks
// - stop needs stop entry enable set
// - exit only on reset or interrupt
// - wake level must exceed threshold
// - wake level must exceed core mask
// - wake source unmasked and module enabled
// - wait stops only cpu, memory clocks
// - doze as wait, peripherals own doze
// - stop halts all system clocks, peripherals freeze
// - disabled peripheral stays disabled throughout
// - core and sram off when low power
// - flash low power when not accessed
// - stop disables sdram controller and refresh
// - threshold encodes minimum waking level
// ============================================================
// power sequencer with apb register slave
module lpm_dev #(
  parameter int NPER = 8                           // gated peripherals
) (
  input  wire logic                      sys_clk_i,
  input  wire logic                      rst_b_i,
  // apb slave
  input  wire logic [lpm_pkg::ADDR_W-1:0] paddr_i,
  input  wire logic                      psel_i,
  input  wire logic                      penable_i,
  input  wire logic                      pwrite_i,
  input  wire logic [31:0]               pwdata_i,
  output logic [31:0]                    prdata_o,
  output logic                           pready_o,
  output logic                           pslverr_o,
  // link
  lpm_if.dev                             lnk,
  // user side
  input  wire logic                      power_down_req_i,   // regulator power-down request
  input  wire logic                      reset_ctrl_voltage_detect_enable_i,
  input  wire logic [NPER-1:0]           periph_sw_disable_i, // software shut-down
  input  wire logic                      flash_access_i,     // flash being accessed
  output logic                           mem_clk_en_o,       // sram clock enable
  output logic                           sys_clk_en_o,       // system clock gate
  output logic                           doze_o,             // peripherals doze
  output logic                           clock_output_pin_en_o,
  output logic                           pll_en_o,
  output logic                           osc_en_o,
  output logic                           power_manager_low_o,
  output logic                           sdram_controller_en_o,
  output logic [NPER-1:0]                periph_clk_en_o,
  output logic                           flash_low_power_o,
  output logic                           regulator_pseudo_standby_o,
  output logic                           regulator_full_standby_o,
  output logic                           low_voltage_detector_en_o,
  output logic [2:0]                     power_state_o
);

  // ==========================================================
  // apb decode
  logic        acc_wr;      // write access phase
  logic        setup_rd;    // read setup phase
  logic        mapped;      // address hits a register
  logic [7:0]  rd_val;      // read mux

  assign mapped   = (paddr_i == lpm_pkg::ADDR_LPC) ||
                    (paddr_i == lpm_pkg::ADDR_WAKE) ||
                    (paddr_i == lpm_pkg::ADDR_STATUS);
  assign acc_wr   = psel_i && penable_i && pwrite_i && mapped;
  assign setup_rd = psel_i && !penable_i && !pwrite_i;
  assign pready_o = 1'b1;                          // zero wait states
  assign pslverr_o = psel_i && penable_i && !mapped;

  // ==========================================================
  // registers
  logic [7:0]  lpc;          // low_power_control
  logic [7:0]  wake_ctl;     // wake_control
  logic [31:0] rdata;        // registered read data
  logic [7:0]  next_lpc;
  logic [7:0]  next_wake_ctl;
  logic [31:0] next_rdata;
  lpm_pkg::lpm_state_t state;

  // read mux, reserved bits read zero
  always_comb begin
    case (paddr_i)
      lpm_pkg::ADDR_LPC:    rd_val = lpc;       // no privilege
      lpm_pkg::ADDR_WAKE:   rd_val = wake_ctl;
      lpm_pkg::ADDR_STATUS: rd_val = {5'h00, state};
      default:              rd_val = 8'h00;     // unmapped reads zero
    endcase
  end

  // register next values; never cleared by wakeup
  always_comb begin
    next_lpc      = lpc;
    next_wake_ctl = wake_ctl;
    next_rdata    = rdata;
    if (acc_wr && paddr_i == lpm_pkg::ADDR_LPC) begin
      next_lpc = pwdata_i[7:0] & lpm_pkg::LPC_WMASK;
    end
    if (acc_wr && paddr_i == lpm_pkg::ADDR_WAKE) begin
      next_wake_ctl = pwdata_i[7:0] & lpm_pkg::WAKE_WMASK;
    end
    if (setup_rd) begin                         // data ready for access phase
      next_rdata = {24'h000000, rd_val};
    end
  end

  // register storage
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lpc      <= lpm_pkg::LPC_RST;
      wake_ctl <= lpm_pkg::WAKE_RST;
      rdata    <= 32'h00000000;
    end else begin
      lpc      <= next_lpc;
      wake_ctl <= next_wake_ctl;
      rdata    <= next_rdata;
    end
  end

  assign prdata_o = rdata;

  // ==========================================================
  // wake qualification
  logic [2:0] thr;          // effective threshold
  logic       wake_ok;      // qualifying request present

  always_comb begin
    thr = wake_ctl[lpm_pkg::THR_HI:lpm_pkg::THR_LO];
    if (thr > lpm_pkg::THR_TOP) begin           // 11x: level seven only
      thr = lpm_pkg::THR_TOP;
    end
    wake_ok = (lnk.irq_level > thr) &&
              (lnk.irq_level > lnk.core_ipl);
  end

  // ==========================================================
  // sequencer
  lpm_pkg::lpm_state_t next_state;
  logic       served;       // halt already acted on
  logic       wake_p;       // wake pulse
  logic [1:0] stp;          // stop select latched at entry
  logic       next_served;
  logic       next_wake_p;
  logic [1:0] next_stp;
  logic       entering;

  // entry on halt, exit on qualified interrupt
  always_comb begin
    next_state  = state;
    next_wake_p = 1'b0;
    next_stp    = stp;
    entering    = 1'b0;
    case (state)
      lpm_pkg::LPM_ST_RUN: begin
        if (lnk.halt && lnk.bus_idle && !served) begin
          entering = 1'b1;
          next_stp = lpc[lpm_pkg::STPSEL_HI:lpm_pkg::STPSEL_LO];
          case (lpc[lpm_pkg::MODE_HI:lpm_pkg::MODE_LO])
            lpm_pkg::MODE_STOP: begin
              if (wake_ctl[lpm_pkg::STOP_EN_BIT]) begin
                next_state = lpm_pkg::LPM_ST_STOP;
              end else begin
                next_state = lpm_pkg::LPM_ST_HALT;
              end
            end
            lpm_pkg::MODE_WAIT: next_state = lpm_pkg::LPM_ST_WAIT;
            lpm_pkg::MODE_DOZE: next_state = lpm_pkg::LPM_ST_DOZE;
            default:            next_state = lpm_pkg::LPM_ST_HALT;
          endcase
        end
      end
      lpm_pkg::LPM_ST_HALT,
      lpm_pkg::LPM_ST_WAIT,
      lpm_pkg::LPM_ST_DOZE,
      lpm_pkg::LPM_ST_STOP: begin
        if (wake_ok) begin                      // only irq; reset is async
          next_state  = lpm_pkg::LPM_ST_RUN;
          next_wake_p = 1'b1;
        end
      end
      default: next_state = lpm_pkg::LPM_ST_RUN;
    endcase
    next_served = lnk.halt && (served || entering);  // rearm once halt drops
  end

  // sequencer state
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state  <= lpm_pkg::LPM_ST_RUN;
      served <= 1'b0;
      wake_p <= 1'b0;
      stp    <= lpm_pkg::STP_KEEP_ALL;
    end else begin
      state  <= next_state;
      served <= next_served;
      wake_p <= next_wake_p;
      stp    <= next_stp;
    end
  end

  // ==========================================================
  // clock gating and standby outputs
  logic            lp;                  // wait, doze or stop
  logic            stop;                // stop mode
  logic            g_cpu;
  logic            g_mem;
  logic            g_sys;
  logic            g_doze;
  logic            g_clock_output_pin;
  logic            g_pll;
  logic            g_osc;
  logic            g_pmlow;
  logic            g_sdram;
  logic [NPER-1:0] g_per;
  logic            g_flash;
  logic            g_pseudo;
  logic            g_full;
  logic            g_lvd;
  logic            sel_ok;             // standby bit effective

  // next gate values follow the next state so gates move with it
  always_comb begin
    stop     = (next_state == lpm_pkg::LPM_ST_STOP);
    lp       = stop || (next_state == lpm_pkg::LPM_ST_WAIT) ||
               (next_state == lpm_pkg::LPM_ST_DOZE);
    g_cpu    = !lp;
    g_mem    = !lp;
    g_sys    = !stop;                                // gate holds clock low
    g_doze   = (next_state == lpm_pkg::LPM_ST_DOZE);
    g_clock_output_pin = !(stop && next_stp != lpm_pkg::STP_KEEP_ALL);
    g_pll    = !(stop && (next_stp == lpm_pkg::STP_NO_PLL ||
                          next_stp == lpm_pkg::STP_NO_OSC));
    g_osc    = !(stop && next_stp == lpm_pkg::STP_NO_OSC);
    g_pmlow  = stop && next_stp == lpm_pkg::STP_NO_OSC;
    g_sdram  = !stop;                                // refresh stops too
    g_per    = ~periph_sw_disable_i & {NPER{!stop}};
    g_flash  = !flash_access_i;
    sel_ok   = reset_ctrl_voltage_detect_enable_i;
    g_pseudo = power_down_req_i && sel_ok && lpc[lpm_pkg::VOLTAGE_DETECT_STANDBY_SELECT_BIT];
    g_full   = power_down_req_i && !(sel_ok && lpc[lpm_pkg::VOLTAGE_DETECT_STANDBY_SELECT_BIT]);
    g_lvd    = sel_ok && (!power_down_req_i || lpc[lpm_pkg::VOLTAGE_DETECT_STANDBY_SELECT_BIT]);
  end

  // gate registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lnk.cpu_clk_en             <= 1'b1;
      mem_clk_en_o               <= 1'b1;
      sys_clk_en_o               <= 1'b1;
      doze_o                     <= 1'b0;
      clock_output_pin_en_o      <= 1'b1;
      pll_en_o                   <= 1'b1;
      osc_en_o                   <= 1'b1;
      power_manager_low_o        <= 1'b0;
      sdram_controller_en_o      <= 1'b1;
      periph_clk_en_o            <= '0;
      flash_low_power_o          <= 1'b1;
      regulator_pseudo_standby_o <= 1'b0;
      regulator_full_standby_o   <= 1'b0;
      low_voltage_detector_en_o  <= 1'b0;
    end else begin
      lnk.cpu_clk_en             <= g_cpu;
      mem_clk_en_o               <= g_mem;
      sys_clk_en_o               <= g_sys;
      doze_o                     <= g_doze;
      clock_output_pin_en_o      <= g_clock_output_pin;
      pll_en_o                   <= g_pll;
      osc_en_o                   <= g_osc;
      power_manager_low_o        <= g_pmlow;
      sdram_controller_en_o      <= g_sdram;
      periph_clk_en_o            <= g_per;
      flash_low_power_o          <= g_flash;
      regulator_pseudo_standby_o <= g_pseudo;
      regulator_full_standby_o   <= g_full;
      low_voltage_detector_en_o  <= g_lvd;
    end
  end

  assign lnk.wake      = wake_p;
  assign power_state_o = state;

endmodule : lpm_dev
`default_nettype wire

// ---- shared/lpm_pkg.sv ----
// ============================================================
// low-power mode control constants
package lpm_pkg;

  // ==========================================================
  // register map, byte addresses on the apb side
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] ADDR_LPC      = 12'h000; // low_power_control
  localparam logic [11:0] ADDR_WAKE     = 12'h004; // wake_control
  localparam logic [11:0] ADDR_STATUS   = 12'h008; // current power state, read only

  // ==========================================================
  // low_power_control fields
  localparam int          MODE_HI       = 7;       // low_power_mode_select msb
  localparam int          MODE_LO       = 6;       // low_power_mode_select lsb
  localparam int          STPSEL_HI     = 4;       // stop_clock_select msb
  localparam int          STPSEL_LO     = 3;       // stop_clock_select lsb
  localparam int          VOLTAGE_DETECT_STANDBY_SELECT_BIT     = 1;       // voltage_detect_standby_select
  localparam logic [7:0]  LPC_WMASK     = 8'hDA;   // writable bits, reserved bits read zero
  localparam logic [7:0]  LPC_RST       = 8'h00;   // value after reset

  // ==========================================================
  // wake_control fields
  localparam int          STOP_EN_BIT   = 7;       // stop_entry_enable
  localparam int          THR_HI        = 6;       // wake_priority_threshold msb
  localparam int          THR_LO        = 4;       // wake_priority_threshold lsb
  localparam logic [7:0]  WAKE_WMASK    = 8'hF0;   // writable bits
  localparam logic [7:0]  WAKE_RST      = 8'h00;   // value after reset
  localparam logic [2:0]  THR_TOP       = 3'h6;    // 11x both mean level seven only

  // ==========================================================
  // mode select encodings
  localparam logic [1:0]  MODE_RUN      = 2'h0;
  localparam logic [1:0]  MODE_DOZE     = 2'h1;
  localparam logic [1:0]  MODE_WAIT     = 2'h2;
  localparam logic [1:0]  MODE_STOP     = 2'h3;

  // ==========================================================
  // stop clock select encodings
  localparam logic [1:0]  STP_KEEP_ALL  = 2'h0;    // clock output, pll, osc run
  localparam logic [1:0]  STP_NO_CLOCK_OUTPUT_PIN = 2'h1;    // clock output stopped
  localparam logic [1:0]  STP_NO_PLL    = 2'h2;    // pll stopped too
  localparam logic [1:0]  STP_NO_OSC    = 2'h3;    // osc stopped, manager low power

  // ==========================================================
  // power state of the sequencer
  typedef enum logic [2:0] {
    LPM_ST_RUN  = 3'h0,                            // normal operation
    LPM_ST_HALT = 3'h1,                            // halted, every clock running
    LPM_ST_WAIT = 3'h2,                            // cpu and memory clocks off
    LPM_ST_DOZE = 3'h3,                            // as wait, peripherals doze
    LPM_ST_STOP = 3'h4                             // every system clock off
  } lpm_state_t;

endpackage : lpm_pkg

// ---- shared/lpm_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// link between core/interrupt controller and the power sequencer
interface lpm_if;
  logic       halt;        // core: halt instruction executed, level until woken
  logic       bus_idle;    // core: no bus cycle active
  logic [2:0] core_ipl;    // core: status register priority mask
  logic [2:0] irq_level;   // intc: highest unmasked enabled request, 0 none
  logic       wake;        // sequencer: one-cycle exit request
  logic       cpu_clk_en;  // sequencer: cpu clock enable level

  // ==========================================================
  // sequencer end
  modport dev (
    input  halt,
    input  bus_idle,
    input  core_ipl,
    input  irq_level,
    output wake,
    output cpu_clk_en
  );

  // ==========================================================
  // core and interrupt controller end
  modport core (
    output halt,
    output bus_idle,
    output core_ipl,
    output irq_level,
    input  wake,
    input  cpu_clk_en
  );
endinterface : lpm_if
`default_nettype wire

// ---- src/lpm_core.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// core and interrupt controller end of the low-power link
module lpm_core #(
  parameter int NSRC = 8                            // interrupt sources
) (
  input  wire logic            sys_clk_i,
  input  wire logic            rst_b_i,
  lpm_if.core                  lnk,
  input  wire logic            halt_exec_i,         // halt instruction issued, pulse
  input  wire logic            bus_busy_i,          // bus cycle in progress
  input  wire logic [2:0]      sr_ipl_i,            // status register mask
  input  wire logic [NSRC-1:0] src_req_i,           // raw requests
  input  wire logic [NSRC-1:0] src_mod_en_i,        // enable at the module
  input  wire logic [NSRC-1:0] imr_i,               // mask register, 1 masks
  input  wire logic [NSRC*3-1:0] src_level_i,       // 3-bit level per source
  output logic                 halted_o,            // core stopped executing
  output logic                 wake_taken_o,        // pulse, resume to serve irq
  output logic [2:0]           pend_level_o         // level being served
);

  // ==========================================================
  // halt state
  logic       pend;       // halt issued, waiting for bus idle
  logic       halted;     // halt level on the link
  logic       taken;      // wake seen
  logic [2:0] lvl_q;      // captured level
  logic       next_pend;
  logic       next_halted;
  logic       next_taken;
  logic [2:0] next_lvl_q;
  logic [2:0] lvl;        // combinational highest request

  // highest qualifying request; combinational so it works with clocks off
  always_comb begin
    lvl = 3'h0;
    for (int i = 0; i < NSRC; i++) begin
      if (src_req_i[i] && src_mod_en_i[i] && !imr_i[i] &&
          src_level_i[i*3 +: 3] > lvl) begin
        lvl = src_level_i[i*3 +: 3];
      end
    end
  end

  // halt handshake next values
  always_comb begin
    next_pend   = pend;
    next_halted = halted;
    next_taken  = 1'b0;
    next_lvl_q  = lvl_q;
    if (halted) begin
      if (lnk.wake) begin                       // woken: resume, serve irq
        next_halted = 1'b0;
        next_taken  = 1'b1;
        next_lvl_q  = lvl;
      end
    end else if (halt_exec_i || pend) begin
      next_pend = 1'b1;
      if (!bus_busy_i) begin                    // idle before halting
        next_pend   = 1'b0;
        next_halted = 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pend   <= 1'b0;
      halted <= 1'b0;
      taken  <= 1'b0;
      lvl_q  <= 3'h0;
    end else begin
      pend   <= next_pend;
      halted <= next_halted;
      taken  <= next_taken;
      lvl_q  <= next_lvl_q;
    end
  end

  // link and user outputs
  assign lnk.halt      = halted;
  assign lnk.bus_idle  = !bus_busy_i;
  assign lnk.core_ipl  = sr_ipl_i;
  assign lnk.irq_level = lvl;
  assign halted_o      = halted;
  assign wake_taken_o  = taken;
  assign pend_level_o  = lvl_q;

endmodule : lpm_core
`default_nettype wire

// ---- tb/lpm_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
// ============================================================
// link watcher between the core end and the sequencer end
module lpm_checker (
  input wire logic       sys_clk_i,
  input wire logic       rst_b_i,
  input wire logic       halt,        // core halted
  input wire logic       bus_idle,    // no bus cycle
  input wire logic [2:0] core_ipl,    // core priority mask
  input wire logic [2:0] irq_level,   // qualified request level
  input wire logic       wake,        // exit pulse
  input wire logic       cpu_clk_en   // cpu clock enable
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ============================================================
  // exit pulse shape and cause
  property p_wake_one;  wake |=> !wake; endproperty
  property p_wake_ipl;  wake |-> $past(irq_level) > $past(core_ipl); endproperty
  property p_wake_src;  wake |-> $past(irq_level) != 3'h0; endproperty
  property p_wake_halt; wake |-> $past(halt); endproperty
  // clocks back at once and kept on after exit
  property p_wake_clk;  wake |-> cpu_clk_en; endproperty
  property p_stay_on;   wake |=> cpu_clk_en [*2]; endproperty
  // clock gating only from an idle halted core
  property p_off_entry; $fell(cpu_clk_en) |-> $past(halt) && $past(bus_idle); endproperty
  property p_run_clk;   !halt |-> cpu_clk_en; endproperty
  a_wake_one: assert property (p_wake_one)
    else $error("wake wider than one cycle");
  a_wake_ipl: assert property (p_wake_ipl)
    else $error("wake with level not above core mask");
  a_wake_src: assert property (p_wake_src)
    else $error("wake without a request");
  a_wake_halt: assert property (p_wake_halt)
    else $error("wake outside low power");
  a_wake_clk: assert property (p_wake_clk)
    else $error("cpu clock late after wake");
  a_stay_on: assert property (p_stay_on)
    else $error("cpu clock dropped right after wake");
  a_off_entry: assert property (p_off_entry)
    else $error("cpu clock stopped without idle halt");
  a_run_clk: assert property (p_run_clk)
    else $error("cpu clock off while running");
  c_wake: cover property (wake);
  c_entry: cover property ($fell(cpu_clk_en));
  c_busy_halt: cover property (halt && !bus_idle);
endmodule : lpm_checker
`default_nettype wire

// ---- tb/test_low_power_mode_control.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_low_power_mode_control;
  // ============================================================
  // stimulus and observed signals
  logic        sys_clk_i = 1'b0, rst_b_i = 1'b0, psel_i = 1'b0, penable_i = 1'b0;
  logic        pwrite_i = 1'b0, pready_o, pslverr_o, halted_o, wake_taken_o;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0, prdata_o, rd, r;
  logic        power_down_req_i = 1'b0, reset_ctrl_voltage_detect_enable_i = 1'b0;
  logic        flash_access_i = 1'b0, halt_exec_i = 1'b0, bus_busy_i = 1'b0, er, q;
  logic [7:0]  periph_sw_disable_i = 8'h00, periph_clk_en_o, lpc;
  logic        mem_clk_en_o, sys_clk_en_o, doze_o, clock_output_pin_en_o, pll_en_o, osc_en_o;
  logic        power_manager_low_o, sdram_controller_en_o, flash_low_power_o;
  logic        regulator_pseudo_standby_o, regulator_full_standby_o, low_voltage_detector_en_o;
  logic [2:0]  power_state_o, sr_ipl_i = 3'h0, pend_level_o, st, thr;
  logic [7:0]  src_req_i = 8'h00, src_mod_en_i = 8'h00, imr_i = 8'h00;
  logic [23:0] src_level_i = 24'h0;
  int          fails = 0, tests_run = 0;
  // ============================================================
  // both ends joined by the link, watcher beside it
  lpm_if lnk ();
  lpm_dev i_lpm_dev (.sys_clk_i, .rst_b_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .pslverr_o, .lnk, .power_down_req_i, .reset_ctrl_voltage_detect_enable_i,
    .periph_sw_disable_i, .flash_access_i, .mem_clk_en_o, .sys_clk_en_o, .doze_o,
    .clock_output_pin_en_o, .pll_en_o, .osc_en_o, .power_manager_low_o, .sdram_controller_en_o,
    .periph_clk_en_o, .flash_low_power_o, .regulator_pseudo_standby_o, .regulator_full_standby_o,
    .low_voltage_detector_en_o, .power_state_o);
  lpm_core i_lpm_core (.sys_clk_i, .rst_b_i, .lnk, .halt_exec_i, .bus_busy_i, .sr_ipl_i,
    .src_req_i, .src_mod_en_i, .imr_i, .src_level_i, .halted_o, .wake_taken_o, .pend_level_o);
  lpm_checker i_lpm_checker (.sys_clk_i, .rst_b_i, .halt(lnk.halt), .bus_idle(lnk.bus_idle),
    .core_ipl(lnk.core_ipl), .irq_level(lnk.irq_level), .wake(lnk.wake),
    .cpu_clk_en(lnk.cpu_clk_en));
  // 25 MHz clock
  always #20 sys_clk_i = ~sys_clk_i;
  // ============================================================
  // compare, close, bus and wait helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // one apb transfer, request held until pready seen
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= {24'h0, d};
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 16);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    if (n >= 16) begin
      fails++;
      summarize();
    end
  endtask : apb
  // bounded wait for run (want=1) or any low state (want=0)
  task automatic wst(input logic want);
    int n;
    n = 0;
    while (((power_state_o === 3'h0) != want) && n < 16) begin
      @(posedge sys_clk_i);
      n++;
    end
    if (n >= 16) begin
      fails++;
      summarize();
    end
  endtask : wst
  // ============================================================
  // main sequence
  initial begin
    void'($urandom(32'h514C));
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    periph_sw_disable_i <= 8'($urandom);
    // lpc reset value, masks, unmapped place
    apb(1'b0, lpm_pkg::ADDR_LPC, 8'h00);
    chk(rd, 32'h0);
    apb(1'b1, lpm_pkg::ADDR_LPC, 8'hFF);
    apb(1'b0, lpm_pkg::ADDR_LPC, 8'h00);
    chk(rd, {24'h0, lpm_pkg::LPC_WMASK});
    apb(1'b1, lpm_pkg::ADDR_WAKE, 8'hFF);
    apb(1'b0, lpm_pkg::ADDR_WAKE, 8'h00);
    chk(rd, {24'h0, lpm_pkg::WAKE_WMASK});
    apb(1'b0, 12'h00C, 8'h00);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    // standby selection over every input combination
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, lpm_pkg::ADDR_LPC, {6'h0, i[2], 1'b0});
      {power_down_req_i, reset_ctrl_voltage_detect_enable_i, flash_access_i} <= {i[1:0], i[0]};
      repeat (2) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk(low_voltage_detector_en_o, i[0] & (!i[1] | i[2]));
      chk(regulator_pseudo_standby_o, i[0] & i[1] & i[2]);
      chk(regulator_full_standby_o, i[1] & !(i[0] & i[2]));
      chk(flash_low_power_o, !i[0]);
    end
    {power_down_req_i, reset_ctrl_voltage_detect_enable_i, flash_access_i} <= 3'h0;
    // every mode, stop enable and stop clock select, then wake
    for (int it = 0; it < 32; it++) begin
      r = $urandom;
      thr = r[2:0];
      lpc = {it[1:0], 1'b0, it[4:3], 3'h0};
      st = (it[1:0] == 2'h0 || (it[1:0] == 2'h3 && !it[2])) ? 3'h1 :
           (it[1:0] == 2'h3) ? 3'h4 : (it[1:0] == 2'h2) ? 3'h2 : 3'h3;
      apb(1'b1, lpm_pkg::ADDR_WAKE, {it[2], thr, 4'h0});
      apb(1'b1, lpm_pkg::ADDR_LPC, lpc);
      @(posedge sys_clk_i);
      sr_ipl_i <= r[5:3];
      bus_busy_i <= 1'b1;
      halt_exec_i <= 1'b1;
      @(posedge sys_clk_i);
      halt_exec_i <= 1'b0;
      repeat (3) @(posedge sys_clk_i);
      chk(power_state_o, 3'h0);
      bus_busy_i <= 1'b0;
      wst(1'b0);
      @(negedge sys_clk_i);
      chk(power_state_o, st);
      chk(lnk.cpu_clk_en, st == 3'h1);
      chk(mem_clk_en_o, st == 3'h1);
      if (st != 3'h4) chk(doze_o, st == 3'h3);
      chk(sys_clk_en_o, st != 3'h4);
      chk(sdram_controller_en_o, st != 3'h4);
      chk(clock_output_pin_en_o, st != 3'h4 || it[4:3] == 0);
      chk(pll_en_o, st != 3'h4 || it[4:3] < 2);
      chk(osc_en_o, st != 3'h4 || it[4:3] != 3);
      chk(power_manager_low_o, st == 3'h4 && it[4:3] == 3);
      chk(periph_clk_en_o, st == 3'h4 ? 32'h0 : {24'h0, ~periph_sw_disable_i});
      chk({halted_o, flash_low_power_o}, 2'h3);
      apb(1'b1, lpm_pkg::ADDR_LPC, lpc ^ 8'hC0);
      chk(power_state_o, st);
      src_level_i <= {21'h0, r[8:6]};
      src_mod_en_i <= {7'h0, r[9]};
      imr_i <= {7'h0, r[10]};
      src_req_i <= 8'h01;
      q = r[9] && !r[10] && r[8:6] > r[5:3] && r[8:6] > (thr == 3'h7 ? 3'h6 : thr);
      repeat (4) @(posedge sys_clk_i);
      @(negedge sys_clk_i);
      chk(power_state_o == 3'h0, q);
      @(posedge sys_clk_i);
      if (!q) begin
        {src_mod_en_i, imr_i, src_level_i, sr_ipl_i} <= {8'h01, 8'h00, 24'h7, 3'h0};
      end
      wst(1'b1);
      @(negedge sys_clk_i);
      chk({lnk.cpu_clk_en, mem_clk_en_o, sys_clk_en_o, sdram_controller_en_o}, 4'hF);
      chk(wake_taken_o, !q);
      repeat (3) @(posedge sys_clk_i);
      chk({halted_o, pend_level_o}, {1'b0, q ? r[8:6] : 3'h7});
      src_req_i <= 8'h00;
      apb(1'b0, lpm_pkg::ADDR_LPC, 8'h00);
      chk(rd, {24'h0, lpc ^ 8'hC0});
    end
    // reset from a low state
    apb(1'b1, lpm_pkg::ADDR_LPC, 8'h80);
    halt_exec_i <= 1'b1;
    @(posedge sys_clk_i);
    halt_exec_i <= 1'b0;
    wst(1'b0);
    rst_b_i <= 1'b0;
    @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    @(negedge sys_clk_i);
    chk({power_state_o, halted_o, lnk.cpu_clk_en}, 5'h01);
    summarize();
  end
endmodule : test_low_power_mode_control
`default_nettype wire
